// ### cscc_pkg.sv
package cscc_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int POR_TIME_US = 100;
    localparam int POR_CYCLES = (POR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POR_CNT_W = 24;
    localparam int INIT_CYCLES = 16;
    localparam int INIT_CNT_W = 8;
    localparam logic [POR_CNT_W-1:0] POR_CNT_ZERO = 24'h000000;
    localparam logic [POR_CNT_W-1:0] POR_CNT_ONE = 24'h000001;
    localparam logic [INIT_CNT_W-1:0] INIT_CNT_ZERO = 8'h00;
    localparam logic [INIT_CNT_W-1:0] INIT_CNT_ONE = 8'h01;

    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CSCC_ST_POR = 3'h0,
        CSCC_ST_WAIT = 3'h1,
        CSCC_ST_CFG = 3'h2,
        CSCC_ST_DONE_CHK = 3'h3,
        CSCC_ST_INIT = 3'h4,
        CSCC_ST_USER = 3'h5,
        CSCC_ST_ERROR = 3'h6
    } cscc_state_t;

    function automatic logic cscc_in_cfg(input cscc_state_t s);
        return (s == CSCC_ST_CFG) || (s == CSCC_ST_DONE_CHK) || (s == CSCC_ST_INIT);
    endfunction : cscc_in_cfg
endpackage : cscc_pkg

// ### cscc_por_timer.sv
`timescale 1ns/1ps
module cscc_por_timer
    import cscc_pkg::*;
#(
    parameter int POR_COUNT = POR_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Supply status
    input wire logic supply_ok,
    // Result
    output logic por_done
);
    logic [POR_CNT_W-1:0] cnt_r;
    logic [POR_CNT_W-1:0] cnt_nxt;
    logic done_r;
    logic done_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        done_nxt = done_r;
        if (!supply_ok) begin
            cnt_nxt = POR_CNT_ZERO;
            done_nxt = 1'b0;
        end else if (!done_r) begin
            if (cnt_r == POR_CNT_W'(POR_COUNT - 1)) begin
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + POR_CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_r <= POR_CNT_ZERO;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign por_done = done_r;
endmodule : cscc_por_timer

// ### cscc_od_pin.sv
`timescale 1ns/1ps
module cscc_od_pin (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Core side
    input wire logic pull_low,
    output logic level_in,
    // Pin side
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_n
);
    logic oe_n_r;
    logic oe_n_nxt;

    always_comb begin
        oe_n_nxt = !pull_low;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oe_n_r <= 1'b0;
        end else begin
            oe_n_r <= oe_n_nxt;
        end
    end

    assign pin_o = 1'b0;
    assign pin_oe_n = oe_n_r;
    assign level_in = pin_i;
endmodule : cscc_od_pin

// ### cscc_ctrl.sv
// Functional notes
// - Drive status low once supplies work; release after power-on interval.
// - Hold status low while supplies ramp; early configuration attempts fail.
// - Release status after power-on interval; its high level starts configuration.
// - Hold done line low before and throughout configuration.
// - Release done line only after error-free data, before initialization starts.
// - Initialize then enter user mode only if done line senses high.
// - Ignore external low on done line once in user mode.
// - Configure only while active-low chip enable is low; the code checks it only on leaving the wait state.
// - Drive chain-out low once own configuration is complete.
// - In active serial mode, drive memory command output.
// - In active serial mode, drive memory chip-select during configuration.
// - External low on status during configuration or initialization means error.
`timescale 1ns/1ps
module cscc_ctrl
    import cscc_pkg::*;
#(
    parameter int POR_COUNT = POR_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Supplies and mode
    input wire logic supply_ok,
    input wire logic active_serial_mode,
    // Chip enable and chain
    input wire logic chip_en_n,
    output logic chain_out_n,
    // Error status pin
    input wire logic config_error_status_n_i,
    output logic config_error_status_n_o,
    output logic config_error_status_n_oe_n,
    // Done pin
    input wire logic config_complete_flag_i,
    output logic config_complete_flag_o,
    output logic config_complete_flag_oe_n,
    // Loader core
    input wire logic cfg_data_all,
    input wire logic cfg_data_err,
    input wire logic mem_cmd_bit,
    output logic cfg_active,
    output logic user_mode,
    // Serial memory
    output logic serial_mem_cmd_out,
    output logic serial_mem_cs_n
);
    // ------------------------------------------------------------
    // Power-on and pins
    // ------------------------------------------------------------
    logic por_done;
    logic status_low;
    logic status_lvl;
    logic done_low;
    logic done_lvl;
    cscc_state_t st_r;
    cscc_state_t st_nxt;
    logic [INIT_CNT_W-1:0] icnt_r;
    logic [INIT_CNT_W-1:0] icnt_nxt;
    logic chain_r;
    logic chain_nxt;
    logic cmd_r;
    logic cmd_nxt;
    logic cs_r;
    logic cs_nxt;

    cscc_por_timer #(.POR_COUNT(POR_COUNT)) u_por (
        .clk(clk),
        .rst_n(rst_n),
        .supply_ok(supply_ok),
        .por_done(por_done)
    );

    // Status low until power-on done, and in error
    assign status_low = (st_r == CSCC_ST_POR) || (st_r == CSCC_ST_ERROR);

    cscc_od_pin u_status (
        .clk(clk),
        .rst_n(rst_n),
        .pull_low(status_low),
        .level_in(status_lvl),
        .pin_i(config_error_status_n_i),
        .pin_o(config_error_status_n_o),
        .pin_oe_n(config_error_status_n_oe_n)
    );

    // Done low until error-free data received (released from done check on)
    assign done_low = (st_r != CSCC_ST_DONE_CHK) && (st_r != CSCC_ST_INIT)
        && (st_r != CSCC_ST_USER);

    cscc_od_pin u_done (
        .clk(clk),
        .rst_n(rst_n),
        .pull_low(done_low),
        .level_in(done_lvl),
        .pin_i(config_complete_flag_i),
        .pin_o(config_complete_flag_o),
        .pin_oe_n(config_complete_flag_oe_n)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        icnt_nxt = icnt_r;
        case (st_r)
            CSCC_ST_POR: begin
                if (por_done) begin
                    st_nxt = CSCC_ST_WAIT;
                end
            end
            CSCC_ST_WAIT: begin
                if (status_lvl && !chip_en_n && !config_error_status_n_oe_n) begin
                    st_nxt = CSCC_ST_WAIT;
                end else if (status_lvl && !chip_en_n) begin
                    st_nxt = CSCC_ST_CFG;
                end
            end
            CSCC_ST_CFG: begin
                if (!status_lvl || cfg_data_err) begin
                    st_nxt = CSCC_ST_ERROR;
                end else if (cfg_data_all) begin
                    st_nxt = CSCC_ST_DONE_CHK;
                    icnt_nxt = INIT_CNT_ZERO;
                end
            end
            CSCC_ST_DONE_CHK: begin
                if (!status_lvl) begin
                    st_nxt = CSCC_ST_ERROR;
                end else if (done_lvl && !config_complete_flag_oe_n) begin
                    st_nxt = CSCC_ST_DONE_CHK;
                end else if (done_lvl) begin
                    st_nxt = CSCC_ST_INIT;
                end
            end
            CSCC_ST_INIT: begin
                if (!status_lvl) begin
                    st_nxt = CSCC_ST_ERROR;
                end else if (icnt_r == INIT_CNT_W'(INIT_CYCLES - 1)) begin
                    st_nxt = CSCC_ST_USER;
                end else begin
                    icnt_nxt = icnt_r + INIT_CNT_ONE;
                end
            end
            CSCC_ST_USER: begin
                st_nxt = CSCC_ST_USER;
            end
            CSCC_ST_ERROR: begin
                st_nxt = CSCC_ST_ERROR;
            end
            default: begin
                st_nxt = CSCC_ST_POR;
            end
        endcase
        if (!supply_ok) begin
            st_nxt = CSCC_ST_POR;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= CSCC_ST_POR;
            icnt_r <= INIT_CNT_ZERO;
        end else begin
            st_r <= st_nxt;
            icnt_r <= icnt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Chain and serial memory outputs
    // ------------------------------------------------------------
    always_comb begin
        chain_nxt = (st_nxt != CSCC_ST_USER);
        cs_nxt = !(active_serial_mode && (st_nxt == CSCC_ST_CFG));
        cmd_nxt = (active_serial_mode && (st_nxt == CSCC_ST_CFG)) ? mem_cmd_bit : 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chain_r <= 1'b1;
            cs_r <= 1'b1;
            cmd_r <= 1'b1;
        end else begin
            chain_r <= chain_nxt;
            cs_r <= cs_nxt;
            cmd_r <= cmd_nxt;
        end
    end

    assign chain_out_n = chain_r;
    assign serial_mem_cs_n = cs_r;
    assign serial_mem_cmd_out = cmd_r;
    assign cfg_active = cscc_in_cfg(st_r);
    assign user_mode = (st_r == CSCC_ST_USER);

    // ------------------------------------------------------------
    // Assertions: status and done pins
    // ------------------------------------------------------------
    a_status_por: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_POR) |=> !config_error_status_n_oe_n)
        else $error("status not pulled low during power-on");
    a_por_status: assert property (@(posedge clk) disable iff (!rst_n)
        !supply_ok |-> ##2 !config_error_status_n_oe_n)
        else $error("status not pulled low after supply loss");
    a_status_release: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_WAIT) |=> config_error_status_n_oe_n)
        else $error("status not released after power-on");
    a_wait_needs_por: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_WAIT) |-> por_done)
        else $error("status released before power-on done");
    a_status_err: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_ERROR) |=> !config_error_status_n_oe_n)
        else $error("status not pulled low in error");
    a_done_held: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_CFG) |=> !config_complete_flag_oe_n)
        else $error("done line released during configuration");
    a_done_cause: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(config_complete_flag_oe_n) |-> $past(st_r, 2) == CSCC_ST_CFG)
        else $error("done line released without data");
    a_done_init: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_INIT) |-> config_complete_flag_oe_n)
        else $error("done line held during initialization");
    a_done_user: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_USER) |-> config_complete_flag_oe_n)
        else $error("done line pulled low in user mode");

    // ------------------------------------------------------------
    // Assertions: sequencer
    // ------------------------------------------------------------
    a_cfg_needs_por: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_CFG) |-> $past(por_done))
        else $error("configuration before power-on done");
    a_cfg_status: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(cfg_active) |-> $past(status_lvl))
        else $error("configuration started with status low");
    a_ce_gate: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_WAIT && chip_en_n) |=> st_r != CSCC_ST_CFG)
        else $error("configuration started without chip enable");
    a_cfg_ce: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(cfg_active) |-> !$past(chip_en_n))
        else $error("configuration entered with chip enable high");
    a_data_err: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_CFG && cfg_data_err)
        |=> (st_r == CSCC_ST_ERROR) || (st_r == CSCC_ST_POR))
        else $error("configuration accepted with data error");
    a_ext_err: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_CFG && !status_lvl && supply_ok) |=> st_r == CSCC_ST_ERROR)
        else $error("external status low not taken as error");
    a_err_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_ERROR && supply_ok) |=> st_r == CSCC_ST_ERROR)
        else $error("error state left without supply loss");
    a_init_gate: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_DONE_CHK && !done_lvl && supply_ok && status_lvl)
        |=> st_r == CSCC_ST_DONE_CHK)
        else $error("initialization with done line low");
    a_init_len: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(user_mode) |-> ($past(st_r, INIT_CYCLES) == CSCC_ST_INIT)
        && ($past(st_r, INIT_CYCLES + 1) == CSCC_ST_DONE_CHK))
        else $error("initialization length wrong");
    a_user_stay: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_USER && supply_ok) |=> st_r == CSCC_ST_USER)
        else $error("user mode left");

    // ------------------------------------------------------------
    // Assertions: chain and serial memory
    // ------------------------------------------------------------
    a_chain_low: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_USER) |-> !chain_out_n)
        else $error("chain-out not low after completion");
    a_chain_user: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(chain_out_n) |-> user_mode)
        else $error("chain-out fell outside user mode");
    a_chain_high: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r != CSCC_ST_USER) |-> chain_out_n)
        else $error("chain-out low too early");
    a_cs_active: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_CFG && active_serial_mode) |-> !serial_mem_cs_n)
        else $error("memory select not active");
    a_cs_idle: assert property (@(posedge clk) disable iff (!rst_n)
        (st_r != CSCC_ST_CFG) |-> serial_mem_cs_n)
        else $error("memory select active outside configuration");
    a_cs_mode: assert property (@(posedge clk) disable iff (!rst_n)
        !active_serial_mode |=> serial_mem_cs_n)
        else $error("memory select active outside serial mode");
    a_cmd_idle: assert property (@(posedge clk) disable iff (!rst_n)
        serial_mem_cs_n |-> serial_mem_cmd_out)
        else $error("command output active while deselected");
    a_cmd_follow: assert property (@(posedge clk) disable iff (!rst_n)
        !serial_mem_cs_n |-> serial_mem_cmd_out == $past(mem_cmd_bit))
        else $error("command output does not follow loader bit");
    a_cmd_mode: assert property (@(posedge clk) disable iff (!rst_n)
        !active_serial_mode |=> serial_mem_cmd_out)
        else $error("command output active outside serial mode");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    c_user: cover property (@(posedge clk) disable iff (!rst_n) $rose(user_mode));
    c_error: cover property (@(posedge clk) disable iff (!rst_n) st_r == CSCC_ST_ERROR);
    c_as_cfg: cover property (@(posedge clk) disable iff (!rst_n) !serial_mem_cs_n);
    c_ce_refused: cover property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_WAIT) && chip_en_n);
    c_done_held: cover property (@(posedge clk) disable iff (!rst_n)
        (st_r == CSCC_ST_DONE_CHK) && config_complete_flag_oe_n && !done_lvl);
endmodule : cscc_ctrl

// ### cscc_partner.sv
`timescale 1ns/1ps
module cscc_partner (
    // Device pins
    input wire logic status_oe_n,
    input wire logic done_oe_n,
    input wire logic chain_out_n,
    // Faults set by the bench
    input wire logic ext_status_low,
    input wire logic ext_done_low,
    // Resolved wires
    output logic status_wire,
    output logic done_wire,
    output logic next_chip_en_n
);
    // ----------------------------------------
    // Open-drain wires with pull-up
    // ----------------------------------------
    assign status_wire = status_oe_n & ~ext_status_low;
    assign done_wire = done_oe_n & ~ext_done_low;
    // ----------------------------------------
    // Next device in the chain
    // ----------------------------------------
    assign next_chip_en_n = chain_out_n;
endmodule : cscc_partner

// ### cscc_ctrl_bench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fails++; \
    $display("MISMATCH %s exp=%0h got=%0h", nm, ex, got); end end
module cscc_ctrl_bench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int POR_N = 8;
    localparam int CYC_MAX = 4000;
    localparam int WAIT_MAX = 60;
    typedef struct packed {logic as; logic ce_n; logic err; logic cfg; logic usr;} cscc_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic supply_ok = 1'b1;
    logic as_mode = 1'b0;
    logic chip_en_n = 1'b0;
    logic ext_s = 1'b0;
    logic ext_d = 1'b0;
    logic data_all = 1'b0;
    logic data_err = 1'b0;
    logic cmd_bit = 1'b1;
    logic chain_out_n, st_wire, st_o, st_oe_n, dn_wire, dn_o, dn_oe_n;
    logic cfg_active, user_mode, cmd_out, cs_n, next_ce_n;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    cscc_row_t rows [4] = '{5'b10001 | 5'b00010, 5'b00011, 5'b10110, 5'b11000};
    always #4 clk = ~clk;
    // ----------------------------------------
    // Design and far side
    // ----------------------------------------
    cscc_ctrl #(.POR_COUNT(POR_N)) u_dut (.clk(clk), .rst_n(rst_n), .supply_ok(supply_ok),
        .active_serial_mode(as_mode), .chip_en_n(chip_en_n), .chain_out_n(chain_out_n),
        .config_error_status_n_i(st_wire), .config_error_status_n_o(st_o),
        .config_error_status_n_oe_n(st_oe_n), .config_complete_flag_i(dn_wire),
        .config_complete_flag_o(dn_o), .config_complete_flag_oe_n(dn_oe_n),
        .cfg_data_all(data_all), .cfg_data_err(data_err), .mem_cmd_bit(cmd_bit),
        .cfg_active(cfg_active), .user_mode(user_mode), .serial_mem_cmd_out(cmd_out),
        .serial_mem_cs_n(cs_n));
    cscc_partner u_far (.status_oe_n(st_oe_n), .done_oe_n(dn_oe_n), .chain_out_n(chain_out_n),
        .ext_status_low(ext_s), .ext_done_low(ext_d), .status_wire(st_wire),
        .done_wire(dn_wire), .next_chip_en_n(next_ce_n));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic pick(input int sel);
        case (sel)
            0: return st_oe_n;
            1: return cfg_active;
            default: return user_mode;
        endcase
    endfunction : pick
    task automatic wait_for(input int sel, output int k);
        k = 0;
        while (pick(sel) !== 1'b1 && k < WAIT_MAX) begin
            @(negedge clk);
            k++;
        end
    endtask : wait_for
    task automatic pulse(input logic err);
        data_err = err;
        data_all = ~err;
        @(negedge clk);
        data_err = 1'b0;
        data_all = 1'b0;
    endtask : pulse
    task automatic power_up();
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        `CHK("status_oe_n", 1'b0, st_oe_n)
        `CHK("done_oe_n", 1'b0, dn_oe_n)
        `CHK("status_o", 1'b0, st_o)
        `CHK("done_o", 1'b0, dn_o)
        `CHK("chain_out_n", 1'b1, chain_out_n)
        rst_n = 1'b1;
        wait_for(0, n);
        `CHK("por_edges", POR_N + 2, n)
    endtask : power_up
    task automatic give_verdict();
        $display("COUNTS compares=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        cyc++;
        if (cyc == CYC_MAX) begin
            fails++;
            give_verdict();
        end
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        @(negedge clk);
        foreach (rows[i]) begin
            as_mode = rows[i].as;
            chip_en_n = rows[i].ce_n;
            power_up();
            wait_for(1, n);
            `CHK("cfg_active", rows[i].cfg, cfg_active)
            `CHK("cs_n", ~(rows[i].as & rows[i].cfg), cs_n)
            cmd_bit = 1'b0;
            @(negedge clk);
            `CHK("cmd_out", ~(rows[i].as & rows[i].cfg), cmd_out)
            cmd_bit = 1'b1;
            `CHK("done_oe_n", 1'b0, dn_oe_n)
            `CHK("chain_out_n", 1'b1, chain_out_n)
            pulse(rows[i].err);
            wait_for(2, n);
            `CHK("user_mode", rows[i].usr, user_mode)
            `CHK("done_oe_n", rows[i].usr, dn_oe_n)
            `CHK("init_len", rows[i].usr ? cscc_pkg::INIT_CYCLES + 2 : WAIT_MAX, n)
            `CHK("chain_out_n", ~rows[i].usr, chain_out_n)
            `CHK("next_ce_n", ~rows[i].usr, next_ce_n)
            `CHK("cs_n", 1'b1, cs_n)
            $display("TEST row %0d done", i);
        end
        as_mode = 1'b1;
        chip_en_n = 1'b0;
        power_up();
        wait_for(1, n);
        ext_d = 1'b1;
        pulse(1'b0);
        repeat (40) @(negedge clk);
        `CHK("held_user", 1'b0, user_mode)
        `CHK("held_cfg", 1'b1, cfg_active)
        ext_d = 1'b0;
        wait_for(2, n);
        `CHK("user_mode", 1'b1, user_mode)
        ext_d = 1'b1;
        repeat (5) @(negedge clk);
        `CHK("user_kept", 1'b1, user_mode)
        `CHK("chain_kept", 1'b0, chain_out_n)
        ext_d = 1'b0;
        $display("TEST done line low done");
        supply_ok = 1'b0;
        repeat (3) @(negedge clk);
        `CHK("status_oe_n", 1'b0, st_oe_n)
        `CHK("user_mode", 1'b0, user_mode)
        `CHK("chain_out_n", 1'b1, chain_out_n)
        supply_ok = 1'b1;
        wait_for(0, n);
        `CHK("por_wait", POR_N + 2, n)
        wait_for(1, n);
        `CHK("reconfig", 1'b1, cfg_active)
        $display("TEST supply loss done");
        ext_s = 1'b1;
        @(negedge clk);
        ext_s = 1'b0;
        pulse(1'b0);
        wait_for(2, n);
        `CHK("err_user", 1'b0, user_mode)
        `CHK("err_cfg", 1'b0, cfg_active)
        `CHK("err_chain", 1'b1, chain_out_n)
        $display("TEST status pulled low done");
        give_verdict();
    end
endmodule : cscc_ctrl_bench
